// file: mie_map.vh
// constants of the instruction execute unit
`ifndef MIE_MAP_VH
`define MIE_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MIE_OFF_CMD      8'h00
`define MIE_OFF_OPND     8'h04
`define MIE_OFF_WORK     8'h08
`define MIE_OFF_STATUS   8'h0C
`define MIE_OFF_PC       8'h10
`define MIE_OFF_WDT      8'h14
`define MIE_OFF_MEMADDR  8'h18
`define MIE_OFF_MEMDATA  8'h1C
// ----------------------------------------
// command register fields
// ----------------------------------------
`define MIE_CMD_OP_LSB   0
`define MIE_CMD_OP_MSB   4
`define MIE_CMD_BIT_LSB  8
`define MIE_CMD_BIT_MSB  10
`define MIE_CMD_ADDR_LSB 16
`define MIE_CMD_ADDR_MSB 23
// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define MIE_ST_C         0
`define MIE_ST_AC        1
`define MIE_ST_Z         2
`define MIE_ST_OV        3
`define MIE_ST_PDF       4
`define MIE_ST_TO        5
`define MIE_ST_BUSY      6
`define MIE_ST_HALTED    7
// ----------------------------------------
// opcodes
// ----------------------------------------
`define MIE_OP_NOP       5'h00
`define MIE_OP_ADC       5'h01
`define MIE_OP_ADD_CARRY_TO_MEMORY      5'h02
`define MIE_OP_ADD       5'h03
`define MIE_OP_ADDI      5'h04
`define MIE_OP_SUM_TO_MEMORY      5'h05
`define MIE_OP_AND       5'h06
`define MIE_OP_ANDI      5'h07
`define MIE_OP_MASK_TO_MEMORY      5'h08
`define MIE_OP_OR        5'h09
`define MIE_OP_ORI       5'h0A
`define MIE_OP_ORM       5'h0B
`define MIE_OP_CALL      5'h0C
`define MIE_OP_JMP       5'h0D
`define MIE_OP_CLRM      5'h0E
`define MIE_OP_CLRB      5'h0F
`define MIE_OP_CLRWDT    5'h10
`define MIE_OP_WDT1      5'h11
`define MIE_OP_WDT2      5'h12
`define MIE_OP_CPL       5'h13
`define MIE_OP_INVERT_TO_WORK_REG      5'h14
`define MIE_OP_DAA       5'h15
`define MIE_OP_DEC       5'h16
`define MIE_OP_DECREMENT_TO_WORK_REG      5'h17
`define MIE_OP_HALT      5'h18
`define MIE_OP_INC       5'h19
`define MIE_OP_INCREMENT_TO_WORK_REG      5'h1A
`define MIE_OP_MOVAM     5'h1B
`define MIE_OP_MOVAI     5'h1C
`define MIE_OP_MOVMA     5'h1D
`define MIE_OP_RET       5'h1E
// ----------------------------------------
// reset values and misc
// ----------------------------------------
`define MIE_RST_BYTE     8'h00
`define MIE_RST_PC       11'h000
`define MIE_PCL_ADDR     8'h02
`define MIE_BCD_LIM      4'h9
`define MIE_BCD_LO       8'h06
`define MIE_BCD_HI       8'h60
`endif

// file: mie_core.v
// instruction execute unit with wishbone register port
// How it works
// - add-with-carry sums work reg, memory byte, carry; sets OV Z AC C
// - plain add sums work reg with memory or immediate; sets four flags
// - AND with memory or immediate; only Z changes
// - OR with memory or immediate; only Z changes
// - call pushes pc plus one, loads target; two cycles, no flags
// - jump loads target with one dummy cycle; no flags
// - clear memory writes zero; flags unchanged
// - bit clear zeroes one selected bit only; flags unchanged
// - watchdog clear resets counter, clears sleep flag; clears expiry unless the watchdog expires in that same cycle
// - pre-clears act only when alternated; repeats do nothing
// - complement inverts memory byte; only Z; to memory or work reg
// - bcd adjust adds six per nibble over nine or flag; only C
// - decrement memory byte; only Z; to memory or work reg
// - increment memory byte; only Z; to memory or work reg
// - halt stops execution, clears watchdog, sets sleep, clears expiry
// - moves copy memory or immediate to work reg or back; no flags
// - no-operation changes nothing but the program counter
// - return pops stack into program counter; no flags
// - writing program counter low byte takes two cycles
//
// Chosen here: register access over Wishbone and the placing of the registers.
`include "mie_map.vh"
module mie_core #(
    parameter MEM_DEPTH   = 256,
    parameter STACK_DEPTH = 8,
    parameter WDT_WIDTH   = 16
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        wake_i,
    output wire        sleep_o,
    output wire        watchdog_expiry_flag,
    output wire        sleep_entered_flag
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_DUMMY = 2'd1;
    localparam ST_HALT  = 2'd2;

    reg [7:0]  mem_q [0:MEM_DEPTH-1];
    reg [10:0] stack_q [0:STACK_DEPTH-1];
    reg [2:0]  sp_q;
    reg [1:0]  st_q;
    reg [7:0]  main_work_register_q;
    reg [10:0] pc_q;
    reg        c_q;
    reg        ac_q;
    reg        z_q;
    reg        ov_q;
    reg        to_q;
    reg        pdf_q;
    reg [1:0]  last_pre_q;
    reg [WDT_WIDTH-1:0] watchdog_counter_q;
    reg [7:0]  presc_q;
    reg [7:0]  opnd_q;
    reg [7:0]  maddr_q;
    reg        wake_s1_q;
    reg        wake_s2_q;

    assign watchdog_expiry_flag = to_q;
    assign sleep_entered_flag   = pdf_q;
    assign sleep_o              = (st_q == ST_HALT);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        acc_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = acc_w & wb_we_i;
    wire        cmd_go  = wr & (wb_adr_i == `MIE_OFF_CMD) & wb_sel_i[0] & (st_q == ST_IDLE);
    wire [4:0]  op      = wb_dat_i[`MIE_CMD_OP_MSB:`MIE_CMD_OP_LSB];
    wire [2:0]  bsel    = wb_dat_i[`MIE_CMD_BIT_MSB:`MIE_CMD_BIT_LSB];
    wire [7:0]  arg     = wb_dat_i[`MIE_CMD_ADDR_MSB:`MIE_CMD_ADDR_LSB];
    wire [7:0]  m       = mem_q[arg];
    wire [7:0]  a       = main_work_register_q;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    reg  [8:0]  sum;
    reg  [4:0]  hsum;
    reg  [7:0]  addend;
    reg         cin;
    reg  [7:0]  res;
    reg  [7:0]  daa_add;
    reg  [8:0]  daa_sum;
    always @*
    begin
        addend = m;
        cin    = 1'b0;
        if (op == `MIE_OP_ADDI)
            addend = opnd_q;
        if (op == `MIE_OP_ADC || op == `MIE_OP_ADD_CARRY_TO_MEMORY)
            cin = c_q;
        sum  = {1'b0, a} + {1'b0, addend} + {8'h00, cin};
        hsum = {1'b0, a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        daa_add = 8'h00;
        if (a[3:0] > `MIE_BCD_LIM || ac_q)
            daa_add = daa_add | `MIE_BCD_LO;
        if (a[7:4] > `MIE_BCD_LIM || c_q)
            daa_add = daa_add | `MIE_BCD_HI;
        daa_sum = {1'b0, a} + {1'b0, daa_add};
        case (op)
            `MIE_OP_AND:  res = a & m;
            `MIE_OP_MASK_TO_MEMORY: res = a & m;
            `MIE_OP_ANDI: res = a & opnd_q;
            `MIE_OP_OR:   res = a | m;
            `MIE_OP_ORM:  res = a | m;
            `MIE_OP_ORI:  res = a | opnd_q;
            `MIE_OP_CPL:  res = ~m;
            `MIE_OP_INVERT_TO_WORK_REG: res = ~m;
            `MIE_OP_DEC:  res = m - 8'h01;
            `MIE_OP_DECREMENT_TO_WORK_REG: res = m - 8'h01;
            `MIE_OP_INC:  res = m + 8'h01;
            `MIE_OP_INCREMENT_TO_WORK_REG: res = m + 8'h01;
            `MIE_OP_CLRB: res = m & ~(8'h01 << bsel);
            `MIE_OP_DAA:  res = daa_sum[7:0];
            default:      res = sum[7:0];
        endcase
    end

    wire is_arith = (op == `MIE_OP_ADC) | (op == `MIE_OP_ADD_CARRY_TO_MEMORY) | (op == `MIE_OP_ADD)
                  | (op == `MIE_OP_ADDI) | (op == `MIE_OP_SUM_TO_MEMORY);
    wire is_zonly = (op == `MIE_OP_AND) | (op == `MIE_OP_ANDI) | (op == `MIE_OP_MASK_TO_MEMORY)
                  | (op == `MIE_OP_OR) | (op == `MIE_OP_ORI) | (op == `MIE_OP_ORM)
                  | (op == `MIE_OP_CPL) | (op == `MIE_OP_INVERT_TO_WORK_REG) | (op == `MIE_OP_DEC)
                  | (op == `MIE_OP_DECREMENT_TO_WORK_REG) | (op == `MIE_OP_INC) | (op == `MIE_OP_INCREMENT_TO_WORK_REG);
    wire to_acc   = (op == `MIE_OP_ADC) | (op == `MIE_OP_ADD) | (op == `MIE_OP_ADDI)
                  | (op == `MIE_OP_AND) | (op == `MIE_OP_ANDI) | (op == `MIE_OP_OR)
                  | (op == `MIE_OP_ORI) | (op == `MIE_OP_INVERT_TO_WORK_REG) | (op == `MIE_OP_DECREMENT_TO_WORK_REG)
                  | (op == `MIE_OP_INCREMENT_TO_WORK_REG);
    wire to_mem   = (op == `MIE_OP_ADD_CARRY_TO_MEMORY) | (op == `MIE_OP_SUM_TO_MEMORY) | (op == `MIE_OP_MASK_TO_MEMORY)
                  | (op == `MIE_OP_ORM) | (op == `MIE_OP_CPL) | (op == `MIE_OP_DEC)
                  | (op == `MIE_OP_INC) | (op == `MIE_OP_CLRB) | (op == `MIE_OP_DAA)
                  | (op == `MIE_OP_CLRM) | (op == `MIE_OP_MOVMA);
    wire [7:0] mem_wd = (op == `MIE_OP_CLRM)  ? `MIE_RST_BYTE :
                        (op == `MIE_OP_MOVMA) ? a : res;
    wire ov_new = (a[7] == addend[7]) & (sum[7] != a[7]);
    // a memory write to the program counter low byte costs a dummy cycle
    wire pcl_hit = to_mem & (arg == `MIE_PCL_ADDR);
    wire two_cyc = pcl_hit | (op == `MIE_OP_CALL) | (op == `MIE_OP_JMP)
                 | (op == `MIE_OP_RET);
    wire pre_ok  = (op == `MIE_OP_WDT1 && last_pre_q == 2'd2)
                 | (op == `MIE_OP_WDT2 && last_pre_q == 2'd1);
    wire wdt_clr = (op == `MIE_OP_CLRWDT) | pre_ok | (op == `MIE_OP_HALT);
    // expiry in the same cycle as a clear command other than halt keeps the flag set; halt clears it
    wire wdt_wrap = (st_q != ST_HALT) & (presc_q == 8'hFF) & (&watchdog_counter_q);

    // ----------------------------------------
    // execution
    // ----------------------------------------
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q                 <= ST_IDLE;
            main_work_register_q <= `MIE_RST_BYTE;
            pc_q                 <= `MIE_RST_PC;
            sp_q                 <= 3'd0;
            c_q                  <= 1'b0;
            ac_q                 <= 1'b0;
            z_q                  <= 1'b0;
            ov_q                 <= 1'b0;
            to_q                 <= 1'b0;
            pdf_q                <= 1'b0;
            last_pre_q           <= 2'd0;
            watchdog_counter_q   <= {WDT_WIDTH{1'b0}};
            presc_q              <= 8'h00;
            opnd_q               <= 8'h00;
            maddr_q              <= 8'h00;
            wake_s1_q            <= 1'b0;
            wake_s2_q            <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_i;
            wake_s2_q <= wake_s1_q;
            // watchdog counts while not halted
            if (st_q != ST_HALT)
            begin
                presc_q <= presc_q + 8'h01;
                if (presc_q == 8'hFF)
                begin
                    watchdog_counter_q <= watchdog_counter_q + 1'b1;
                    if (&watchdog_counter_q)
                        to_q <= 1'b1;
                end
            end
            if (wr && wb_adr_i == `MIE_OFF_OPND && wb_sel_i[0])
                opnd_q <= wb_dat_i[7:0];
            if (wr && wb_adr_i == `MIE_OFF_MEMADDR && wb_sel_i[0])
                maddr_q <= wb_dat_i[7:0];
            if (wr && wb_adr_i == `MIE_OFF_WORK && wb_sel_i[0] && st_q == ST_IDLE)
                main_work_register_q <= wb_dat_i[7:0];
            case (st_q)
                ST_IDLE:
                begin
                    if (cmd_go) // ops outside every decode list only advance the program counter
                    begin
                        pc_q <= pc_q + 11'd1;
                        if (two_cyc)
                            st_q <= ST_DUMMY;
                        if (to_acc)
                            main_work_register_q <= res;
                        if (op == `MIE_OP_MOVAM)
                            main_work_register_q <= m;
                        if (op == `MIE_OP_MOVAI)
                            main_work_register_q <= opnd_q;
                        if (is_arith)
                        begin
                            c_q  <= sum[8];
                            ac_q <= hsum[4];
                            ov_q <= ov_new;
                        end
                        if (is_arith | is_zonly)
                            z_q <= (res == 8'h00);
                        if (op == `MIE_OP_DAA)
                            c_q <= c_q | daa_sum[8];
                        if (op == `MIE_OP_CALL)
                        begin
                            stack_q[sp_q] <= pc_q + 11'd1;
                            sp_q <= sp_q + 3'd1;
                            pc_q <= {3'b000, arg};
                        end
                        if (op == `MIE_OP_JMP)
                            pc_q <= {3'b000, arg};
                        if (op == `MIE_OP_RET)
                        begin
                            pc_q <= stack_q[sp_q - 3'd1];
                            sp_q <= sp_q - 3'd1;
                        end
                        if (op == `MIE_OP_WDT1)
                            last_pre_q <= 2'd1;
                        if (op == `MIE_OP_WDT2)
                            last_pre_q <= 2'd2;
                        if (wdt_clr)
                        begin
                            watchdog_counter_q <= {WDT_WIDTH{1'b0}};
                            presc_q <= 8'h00;
                            to_q    <= wdt_wrap & (op != `MIE_OP_HALT);
                            pdf_q   <= (op == `MIE_OP_HALT);
                        end
                        if (op == `MIE_OP_WDT1 || op == `MIE_OP_WDT2)
                            if (pre_ok)
                                last_pre_q <= 2'd0;
                        if (op == `MIE_OP_HALT)
                            st_q <= ST_HALT;
                    end
                end
                ST_DUMMY: st_q <= ST_IDLE;
                ST_HALT:
                    if (wake_s2_q)
                        st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // data memory has no reset; it keeps contents through halt
    always @(posedge clk)
    begin
        if (cmd_go && to_mem)
            mem_q[arg] <= mem_wd;
        else if (wr && wb_adr_i == `MIE_OFF_MEMDATA && wb_sel_i[0] && st_q == ST_IDLE)
            mem_q[maddr_q] <= wb_dat_i[7:0];
    end

    // ----------------------------------------
    // bus answer, one wait-free cycle
    // ----------------------------------------
    wire [7:0] status = {sleep_o, (st_q == ST_DUMMY), to_q, pdf_q, ov_q, z_q, ac_q, c_q};
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= acc_w;
            if (acc_w && !wb_we_i)
                case (wb_adr_i)
                    `MIE_OFF_OPND:    wb_dat_o <= {24'h000000, opnd_q};
                    `MIE_OFF_WORK:    wb_dat_o <= {24'h000000, main_work_register_q};
                    `MIE_OFF_STATUS:  wb_dat_o <= {24'h000000, status};
                    `MIE_OFF_PC:      wb_dat_o <= {21'h000000, pc_q};
                    `MIE_OFF_WDT:     wb_dat_o <= {{(32-WDT_WIDTH){1'b0}}, watchdog_counter_q};
                    `MIE_OFF_MEMADDR: wb_dat_o <= {24'h000000, maddr_q};
                    `MIE_OFF_MEMDATA: wb_dat_o <= {24'h000000, mem_q[maddr_q]};
                    default:          wb_dat_o <= 32'h00000000;
                endcase
        end
    end
endmodule // mie_core

// file: mie_core_assertions.sv
// port-level checks for the instruction execute unit
`include "mie_map.vh"
module mie_chk (
    input wire        clk,
    input wire        rstn,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wake_i,
    input wire        sleep_o,
    input wire        watchdog_expiry_flag,
    input wire        sleep_entered_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire cmd_wr  = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == `MIE_OFF_CMD);
    wire wdt_op  = (wb_dat_i[4:0] == `MIE_OP_CLRWDT) || (wb_dat_i[4:0] == `MIE_OP_WDT1) ||
                   (wb_dat_i[4:0] == `MIE_OP_WDT2) || (wb_dat_i[4:0] == `MIE_OP_HALT);
    // ----------------------------------------
    // bus timing and power-down flags
    // ----------------------------------------
    a_ack_follows_req: assert property (req_new |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!req_new |=> !wb_ack_o)
        else $error("ack without request");
    a_read_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != `MIE_OFF_WDT
        |-> wb_dat_o[31:11] == 21'h0)
        else $error("read data upper bits not zero");
    a_halt_sets_flags: assert property ($rose(sleep_o) |-> sleep_entered_flag && !watchdog_expiry_flag)
        else $error("halt entry flags wrong");
    a_sleep_keeps_flag: assert property (sleep_o |-> sleep_entered_flag)
        else $error("sleep flag low while halted");
    a_sleep_flag_cause: assert property ($rose(sleep_entered_flag) |-> sleep_o)
        else $error("sleep flag set without halt");
    a_flag_clear_cause: assert property ($fell(sleep_entered_flag) || $fell(watchdog_expiry_flag)
        |-> $past(cmd_wr) && $past(wdt_op))
        else $error("watchdog flags cleared without command");
    a_wake_leaves_halt: assert property (sleep_o && wake_i ##1 wake_i [*4] |=> !sleep_o)
        else $error("no exit from halt on wake");
    c_halt: cover property ($rose(sleep_o));
    c_flag_clear: cover property ($fell(sleep_entered_flag));
    c_call: cover property (cmd_wr && wb_dat_i[4:0] == `MIE_OP_CALL);
endmodule // mie_chk

bind mie_core mie_chk mie_chk_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_i(wake_i),
    .sleep_o(sleep_o), .watchdog_expiry_flag(watchdog_expiry_flag),
    .sleep_entered_flag(sleep_entered_flag));

// file: test_mcu_instruction_execute.sv
// self-checking bench for the instruction execute unit
`include "mie_map.vh"
module test_mcu_instruction_execute;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        rstn;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic        wake_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    wire         sleep_o;
    wire         watchdog_expiry_flag;
    wire         sleep_entered_flag;
    int          num_errors;
    int          tests_run;
    logic [31:0] rd;
    logic [31:0] st;
    logic [63:0] e;
    // entry: op with bit index in 7:5, imm, work, mem, work out, mem out, pad, flags
    logic [63:0] alu_tab [0:24] = '{
        64'h0300_8F91_2091_000B, 64'h0100_2091_B291_0000, 64'h044E_B291_0091_0007,
        64'h0200_0091_0092_0000, 64'h0500_7F01_7F80_000A, 64'h0600_F00F_000F_000E,
        64'h07F5_3C00_3400_000A, 64'h0800_0FF0_0F00_000E, 64'h0900_500A_5A0A_000A,
        64'h0A00_0000_0000_000E, 64'h0B00_8142_81C3_000A, 64'h1300_11FF_1100_000E,
        64'h1400_115A_A55A_000A, 64'h1600_1101_1100_000E, 64'h1700_1100_FF00_000A,
        64'h1900_11FF_1100_000E, 64'h1A00_117F_807F_000A, 64'h0E00_115A_1100_000A,
        64'hEF00_11FF_117F_000A, 64'h1B00_113C_3C3C_000A, 64'h1C00_113C_003C_000A,
        64'h1D00_C33C_C3C3_000A, 64'h0000_1122_1122_000A, 64'h1500_3A00_3A40_000A,
        64'h1500_A300_A309_000B};

    mie_core mie_core_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_i(wake_i), .sleep_o(sleep_o),
        .watchdog_expiry_flag(watchdog_expiry_flag), .sleep_entered_flag(sleep_entered_flag));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, rd);
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask
    task automatic exec(input logic [7:0] opb, input logic [7:0] adr);
        int n;
        n = 0;
        wr(`MIE_OFF_CMD, {8'h00, adr, 5'h00, opb[7:5], 3'h0, opb[4:0]});
        do
        begin
            bus(1'b0, `MIE_OFF_STATUS, 32'h0, st);
            n++;
        end
        while (st[`MIE_ST_BUSY] !== 1'b0 && n < 8);
        if (n >= 8)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wake_i} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
        num_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wb_sel_i <= 4'h1;
        rchk(`MIE_OFF_STATUS, 32'h0);
        rchk(`MIE_OFF_WORK, 32'h0);
        wr(8'h24, 32'hFF);
        rchk(8'h24, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 25; i++)
        begin
            e = alu_tab[i];
            wr(`MIE_OFF_WORK, {24'h0, e[47:40]});
            wr(`MIE_OFF_OPND, {24'h0, e[55:48]});
            wr(`MIE_OFF_MEMADDR, 32'h20);
            wr(`MIE_OFF_MEMDATA, {24'h0, e[39:32]});
            exec(e[63:56], 8'h20);
            check({28'h0, st[3:0]}, {28'h0, e[3:0]});
            rchk(`MIE_OFF_WORK, {24'h0, e[31:24]});
            rchk(`MIE_OFF_MEMDATA, {24'h0, e[23:16]});
        end
        $display("test alu done");
        exec({3'h0, `MIE_OP_JMP}, 8'h30);
        rchk(`MIE_OFF_PC, 32'h30);
        exec({3'h0, `MIE_OP_CALL}, 8'h55);
        rchk(`MIE_OFF_PC, 32'h55);
        exec({3'h0, `MIE_OP_RET}, 8'h00);
        rchk(`MIE_OFF_PC, 32'h31);
        rchk(`MIE_OFF_STATUS, 32'h0B);
        $display("test branch done");
        repeat (600) @(posedge clk);
        exec({3'h0, `MIE_OP_WDT1}, 8'h00);
        exec({3'h0, `MIE_OP_WDT1}, 8'h00);
        bus(1'b0, `MIE_OFF_WDT, 32'h0, rd);
        check({31'h0, rd !== 32'h0}, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            exec({3'h0, `MIE_OP_HALT}, 8'h00);
            check({29'h0, watchdog_expiry_flag, sleep_o, sleep_entered_flag}, 32'h3);
            rchk(`MIE_OFF_WDT, 32'h0);
            wr(`MIE_OFF_WORK, 32'h77);
            rchk(`MIE_OFF_STATUS, 32'h9B);
            rchk(`MIE_OFF_WORK, 32'hA3);
            wake_i <= 1'b1;
            repeat (6) @(posedge clk);
            wake_i <= 1'b0;
            rchk(`MIE_OFF_STATUS, 32'h1B);
            exec({3'h0, (k == 0) ? `MIE_OP_WDT1 : `MIE_OP_CLRWDT}, 8'h00);
            check({31'h0, sleep_entered_flag}, {31'h0, k == 0});
            exec({3'h0, `MIE_OP_WDT2}, 8'h00);
            check({31'h0, sleep_entered_flag}, 32'h0);
            bus(1'b0, `MIE_OFF_WDT, 32'h0, rd);
            check({31'h0, rd < 32'h2}, 32'h1);
        end
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule // test_mcu_instruction_execute
